/* File: rtl/codec_global_params.svh */
// Command codes, field positions and reset values of the global config registers.
// Included by the design module global_pcm_pll_config; definitions only.
`ifndef CODEC_GLOBAL_PARAMS_SVH
`define CODEC_GLOBAL_PARAMS_SVH

`define CMD_RW_BIT 7
`define CMD_PLL_RD 8'h20
`define CMD_PLL_WR 8'hA0
`define CMD_RSV_RD 8'h21
`define CMD_RSV_WR 8'hA1
`define CMD_PCM_RD 8'h22
`define CMD_PCM_WR 8'hA2

`define PLL_SHUTDOWN_POS 7
`define PLL_KEEP_MASK 8'h80
`define PLL_RESET 8'h00
`define PCM_RESET 8'h00
`define RSV_READ_VALUE 8'h00

`define BYTE_BITS 4'h8
`define WORD_BITS 5'h10
`define DELAY_W 3
`define DELAY_NONE 3'h0

`endif

/* File: rtl/codec_global_pkg.sv */
// Types shared by the global configuration block.
// Constants live in codec_global_params.svh.
package codec_global_pkg;

  // Highway configuration byte, MSB first
  typedef struct packed {
    logic linear_coding;
    logic [3:0] framing_opts;
    logic [2:0] frame_to_data_delay;
  } pcm_cfg_t;

  typedef enum logic [1:0] {
    PORT_CMD,
    PORT_READ,
    PORT_WRITE,
    PORT_SKIP
  } port_state_t;

endpackage

/* File: rtl/pin_sync3.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the input may change at any time relative to clk.
module pin_sync3 #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= INIT;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      rise <= (s2_r == s3_r) && s3_r && !q;
      fall <= (s2_r == s3_r) && !s3_r && q;
      if (s2_r == s3_r)
      begin
        q <= s3_r;
      end
    end
  end

endmodule

/* File: rtl/global_pcm_pll_config.sv */
// Global registers of the codec: PLL power control, a reserved location and
// the PCM highway configuration, reached through the serial microprocessor port.
// Assumes the host keeps CS_N low for a command byte plus one data byte.
//
// Summary of operation
// - PLL control register is read with 20H and written with A0H.
// - PLL shutdown bit clear keeps PLL powered (reset); set shuts it down.
// - Lower seven PLL control bits have no function and read zero.
// - Second global location is reserved: reads zero, writes ignored.
// - Highway configuration register is read with 22H and written with A2H.
// - Sample-coding bit clear selects 8-bit companded, set selects 16-bit linear.
// - Host writes zeros to reserved bits; device ignores them on readback.
`include "codec_global_params.svh"

module global_pcm_pll_config
  import codec_global_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic MPI_MODE,
  input wire logic CS_N,
  input wire logic CCLK,
  input wire logic CDIN,
  output logic CDOUT,
  output logic CDOUT_OE,
  input wire logic BCLK,
  input wire logic FRAME_SYNC,
  output logic PLL_SHUTDOWN,
  output logic LINEAR_CODING,
  output pcm_cfg_t HWY_CFG,
  output logic HWY_START
);

  logic cs_n_s;
  logic cs_fall;
  logic cclk_rise;
  logic cclk_fall;
  logic din_s;
  logic bclk_rise;
  logic fs_rise;
  logic mpi_s;

  pin_sync3 #(.INIT(1'b1)) u_cs (.clk(REF_CLK), .rst_n(RST_N), .d(CS_N), .q(cs_n_s),
    .rise(), .fall(cs_fall));
  pin_sync3 u_cclk (.clk(REF_CLK), .rst_n(RST_N), .d(CCLK), .q(),
    .rise(cclk_rise), .fall(cclk_fall));
  pin_sync3 u_din (.clk(REF_CLK), .rst_n(RST_N), .d(CDIN), .q(din_s),
    .rise(), .fall());
  pin_sync3 u_bclk (.clk(REF_CLK), .rst_n(RST_N), .d(BCLK), .q(),
    .rise(bclk_rise), .fall());
  pin_sync3 u_fs (.clk(REF_CLK), .rst_n(RST_N), .d(FRAME_SYNC), .q(),
    .rise(fs_rise), .fall());
  pin_sync3 u_mode (.clk(REF_CLK), .rst_n(RST_N), .d(MPI_MODE), .q(mpi_s),
    .rise(), .fall());

  // Serial port
  port_state_t state_r;
  logic [7:0] cmd_r;
  logic [7:0] shin_r;
  logic [7:0] shout_r;
  logic [3:0] bits_r;
  logic first_fall_r;
  logic [7:0] pll_r;
  pcm_cfg_t pcm_r;
  logic [7:0] shin_nxt;
  logic byte_done;
  logic wr_commit;
  logic [7:0] rd_value;

  assign shin_nxt = {shin_r[6:0], din_s};
  assign byte_done = cclk_rise && !cs_n_s && (bits_r == (`BYTE_BITS - 4'h1));
  assign wr_commit = byte_done && (state_r == PORT_WRITE);

  // Read data: reserved bits and the reserved location read as zero
  always_comb
  begin
    case (shin_nxt)
      `CMD_PLL_RD: rd_value = pll_r & `PLL_KEEP_MASK;
      `CMD_RSV_RD: rd_value = `RSV_READ_VALUE;
      `CMD_PCM_RD: rd_value = pcm_r;
      default: rd_value = `RSV_READ_VALUE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      state_r <= PORT_CMD;
      cmd_r <= 8'h00;
      shin_r <= 8'h00;
      bits_r <= 4'h0;
    end
    else if (cs_n_s || cs_fall)
    begin
      state_r <= PORT_CMD;
      bits_r <= 4'h0;
    end
    else if (cclk_rise)
    begin
      shin_r <= shin_nxt;
      bits_r <= byte_done ? 4'h0 : bits_r + 4'h1;
      if (byte_done)
      begin
        case (state_r)
          PORT_CMD:
          begin
            cmd_r <= shin_nxt;
            case (shin_nxt)
              `CMD_PLL_RD, `CMD_RSV_RD, `CMD_PCM_RD: state_r <= PORT_READ;
              `CMD_PLL_WR, `CMD_RSV_WR, `CMD_PCM_WR: state_r <= PORT_WRITE;
              default: state_r <= PORT_SKIP;
            endcase
          end
          default: state_r <= PORT_SKIP;
        endcase
      end
    end
  end

  // Output shifter: loaded after the command, next bit on each falling clock after the first
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      shout_r <= 8'h00;
      first_fall_r <= 1'b0;
    end
    else if (byte_done && (state_r == PORT_CMD))
    begin
      shout_r <= rd_value;
      first_fall_r <= 1'b1;
    end
    else if (cclk_fall && (state_r == PORT_READ))
    begin
      first_fall_r <= 1'b0;
      if (!first_fall_r)
      begin
        shout_r <= {shout_r[6:0], 1'b0};
      end
    end
  end

  assign CDOUT = shout_r[7];
  assign CDOUT_OE = (state_r == PORT_READ) && !cs_n_s;

  // Register writes; reserved PLL bits are dropped, reserved location ignored
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      pll_r <= `PLL_RESET;
      pcm_r <= `PCM_RESET;
    end
    else if (wr_commit)
    begin
      if (cmd_r == `CMD_PLL_WR)
      begin
        pll_r <= shin_nxt & `PLL_KEEP_MASK;
      end
      if (cmd_r == `CMD_PCM_WR)
      begin
        pcm_r <= shin_nxt;
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      PLL_SHUTDOWN <= 1'b0;
      LINEAR_CODING <= 1'b0;
      HWY_CFG <= `PCM_RESET;
    end
    else
    begin
      PLL_SHUTDOWN <= pll_r[`PLL_SHUTDOWN_POS];
      LINEAR_CODING <= pcm_r.linear_coding;
      HWY_CFG <= pcm_r;
    end
  end

  // Highway start after frame sync, delayed by whole bit-clock periods
  logic [`DELAY_W-1:0] delay_eff;
  logic [`DELAY_W-1:0] dly_cnt_r;
  logic dly_busy_r;

  assign delay_eff = mpi_s ? pcm_r.frame_to_data_delay : `DELAY_NONE;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      dly_cnt_r <= `DELAY_NONE;
      dly_busy_r <= 1'b0;
      HWY_START <= 1'b0;
    end
    else if (fs_rise)
    begin
      dly_cnt_r <= delay_eff;
      dly_busy_r <= (delay_eff != `DELAY_NONE);
      HWY_START <= (delay_eff == `DELAY_NONE);
    end
    else if (dly_busy_r && bclk_rise)
    begin
      dly_cnt_r <= dly_cnt_r - 3'h1;
      dly_busy_r <= (dly_cnt_r != 3'h1);
      HWY_START <= (dly_cnt_r == 3'h1);
    end
    else
    begin
      HWY_START <= 1'b0;
    end
  end

  // Checks
  logic [3:0] edges_since_fs;
  logic [2:0] delay_at_fs;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      edges_since_fs <= 4'h0;
      delay_at_fs <= 3'h0;
    end
    else if (fs_rise)
    begin
      edges_since_fs <= 4'h0;
      delay_at_fs <= delay_eff;
    end
    else if (bclk_rise && dly_busy_r)
    begin
      edges_since_fs <= edges_since_fs + 4'h1;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_pll_write;
    wr_commit && (cmd_r == `CMD_PLL_WR);
  endsequence

  sequence s_pcm_write;
    wr_commit && (cmd_r == `CMD_PCM_WR);
  endsequence

  a_pll_write_out: assert property (s_pll_write |-> ##2 PLL_SHUTDOWN == $past(shin_nxt[7], 2))
    else $error("PLL shutdown output does not follow write");
  a_pll_rsv_zero: assert property (pll_r[6:0] == 7'h00)
    else $error("Reserved PLL bits not zero");
  a_rsv_read_zero: assert property (byte_done && state_r == PORT_CMD && shin_nxt == `CMD_RSV_RD
    |=> shout_r == 8'h00)
    else $error("Reserved location reads nonzero");
  a_pcm_write_cfg: assert property (s_pcm_write |-> ##2 HWY_CFG == $past(shin_nxt, 2))
    else $error("Highway config does not follow write");
  a_linear_follow: assert property (s_pcm_write ##2 1 |-> LINEAR_CODING == $past(shin_nxt[7], 2))
    else $error("Coding select does not follow write");
  a_reset_default: assert property ($rose(RST_N) |-> !PLL_SHUTDOWN && !LINEAR_CODING)
    else $error("Defaults wrong after reset");
  a_read_drive: assert property (CDOUT_OE |-> state_r == PORT_READ && cmd_r[`CMD_RW_BIT] == 1'b0)
    else $error("Output enabled outside a read");
  a_delay_zero: assert property (fs_rise && delay_eff == 3'h0 |=> HWY_START)
    else $error("Zero delay start missing");
  a_delay_count: assert property (HWY_START |-> edges_since_fs == {1'b0, delay_at_fs})
    else $error("Highway start at wrong bit clock");

endmodule

/* File: tb/serial_host_model.sv */
// Host side of the serial register port: one command byte, one data byte.
// Assumes clk is the 25 MHz reference; CCLK idles low between frames.
module serial_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic cclk,
  output logic cdin,
  input wire logic cdout,
  input wire logic cdout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;

  initial
  begin
    cs_n = 1'b1;
    cclk = 1'b0;
    cdin = 1'b1;
  end

  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wd,
                      output logic [7:0] rd, output logic oe_seen);
    logic [15:0] frame;
    frame = {wr, addr, wd};
    rd = 8'h00;
    oe_seen = 1'b0;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      cdin <= frame[i];
      repeat (HALF) @(posedge clk);
      if (i < 8)
      begin
        rd[i] = cdout;
        oe_seen = oe_seen | cdout_oe;
      end
      cclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      cclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    // Released line must not keep showing the last bit
    cdin <= ~frame[0];
    repeat (HALF) @(posedge clk);
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the global configuration registers.
// Assumes the serial host model drives the register port.
module tb
  import codec_global_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mpi_mode = 1'b1;
  logic bclk = 1'b0;
  logic frame_sync = 1'b0;
  logic cs_n, cclk, cdin, cdout, cdout_oe, pll_off, linear, hwy_start, oe;
  pcm_cfg_t hwy_cfg;
  logic [7:0] pll_e = 8'h00;
  logic [7:0] pcm_e = 8'h00;
  logic [7:0] rd, v;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  always #20 ref_clk = ~ref_clk;

  global_pcm_pll_config i_global_pcm_pll_config (.REF_CLK(ref_clk), .RST_N(rst_n),
    .MPI_MODE(mpi_mode), .CS_N(cs_n), .CCLK(cclk), .CDIN(cdin), .CDOUT(cdout),
    .CDOUT_OE(cdout_oe), .BCLK(bclk), .FRAME_SYNC(frame_sync), .PLL_SHUTDOWN(pll_off),
    .LINEAR_CODING(linear), .HWY_CFG(hwy_cfg), .HWY_START(hwy_start));

  serial_host_model i_serial_host_model (.clk(ref_clk), .cs_n(cs_n), .cclk(cclk),
    .cdin(cdin), .cdout(cdout), .cdout_oe(cdout_oe));

  task automatic close_out;
    $display("fails %0d checks_done %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] pll_view(input logic [7:0] w);
    return w & 8'h80;
  endfunction

  task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] wd);
    i_serial_host_model.xfer(wr, addr, wd, rd, oe);
  endtask

  task automatic check_outs;
    chk({7'h00, pll_off}, {7'h00, pll_e[7]}, "pll pin");
    chk({7'h00, linear}, {7'h00, pcm_e[7]}, "coding pin");
    chk(hwy_cfg, pcm_e, "cfg pins");
  endtask

  task automatic frame_run(input int exp_d);
    int rises, at, pulses;
    rises = 0;
    at = -1;
    pulses = 0;
    // The previous frame may leave the bit clock high; start every frame from low
    bclk <= 1'b0;
    frame_sync <= 1'b1;
    for (int c = 1; c < 160; c++)
    begin
      @(posedge ref_clk);
      if (hwy_start === 1'b1)
      begin
        pulses++;
        at = rises;
      end
      if (c % 16 == 8)
      begin
        bclk <= 1'b1;
        rises++;
      end
      if (c % 16 == 0)
        bclk <= 1'b0;
    end
    frame_sync <= 1'b0;
    chk(8'(pulses), 8'h01, "start pulses");
    chk(8'(at), 8'(exp_d), "start delay");
  endtask

  initial
  begin
    void'($urandom(32'h328c));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check_outs();
    chk({7'h00, cdout_oe}, 8'h00, "oe idle");
    access(1'b0, 7'h20, 8'h00);
    chk(rd, 8'h00, "pll reset");
    access(1'b0, 7'h22, 8'h00);
    chk(rd, 8'h00, "cfg reset");
    for (int n = 0; n < 6; n++)
    begin
      v = (n == 0) ? 8'hff : 8'($urandom);
      // Host keeps the reserved PLL bits at zero on every write
      access(1'b1, 7'h20, pll_view(v));
      pll_e = pll_view(v);
      access(1'b0, 7'h20, 8'h00);
      chk(rd, pll_e, "pll read");
      chk({7'h00, oe}, 8'h01, "read oe");
      v = (n == 1) ? 8'hff : 8'($urandom);
      access(1'b1, 7'h22, v);
      pcm_e = v;
      access(1'b0, 7'h22, 8'h00);
      chk(rd, pcm_e, "cfg read");
      access(1'b1, 7'h21, 8'($urandom));
      access(1'b0, 7'h21, 8'h00);
      chk(rd, 8'h00, "reserved read");
      check_outs();
    end
    access(1'b0, 7'h30, 8'h00);
    chk({7'h00, oe}, 8'h00, "unknown oe");
    for (int d = 0; d < 8; d++)
    begin
      pcm_e = {pcm_e[7:3], 3'(d)};
      access(1'b1, 7'h22, pcm_e);
      frame_run(d);
    end
    mpi_mode <= 1'b0;
    repeat (8) @(posedge ref_clk);
    frame_run(0);
    close_out();
  end
endmodule
